/* File: hdl/lszd_pkg.sv */
// Purpose: shared constants for the local storage zone decode block
// Assumes: 8-bit local storage bytes, 4-bit operand fields, 3-bit zones
// Notes:   zone codes and field decodes follow the storage map

package lszd_pkg;

  // =========================================================================
  // zone codes
  localparam logic [2:0] ZONE_CPU    = 3'h0;
  localparam logic [2:0] ZONE_DISK   = 3'h1;
  localparam logic [2:0] ZONE_BACKUP = 3'h4;
  localparam logic [2:0] ZONE_COMM   = 3'h5;
  localparam logic [2:0] ZONE_CARD   = 3'h6;
  localparam logic [2:0] ZONE_SPARE7 = 3'h7;

  // =========================================================================
  // field decodes
  localparam logic [3:0] FLD_ICTR_HI     = 4'h8;
  localparam logic [3:0] FLD_ICTR_LO     = 4'h9;
  localparam logic [3:0] FLD_WORK_ZERO   = 4'hA;
  localparam logic [3:0] FLD_COND_CODE   = 4'hC;
  localparam logic [3:0] FLD_PSW_STATE   = 4'hD;
  localparam logic [3:0] FLD_CTR_TOP     = 4'hF;

  // =========================================================================
  // field positions (bit 0 is the most significant bit of a byte)
  localparam int ZONE_POS_LO  = 5;
  localparam int MODE_POS_LO  = 2;
  localparam int DIAG_BR_BIT  = 7;
  localparam int STAT_S7_BIT  = 7;
  localparam int BA_S7_BIT    = 0;
  localparam int MASK_WIDE    = 10;
  localparam int MASK_NARROW  = 8;

  // =========================================================================
  // reset values
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [9:0] MASK_RST   = 10'h000;
  localparam logic [7:0] DIAG_RST   = 8'h00;
  localparam logic [7:0] STAT_RST   = 8'h00;

  // =========================================================================
  // microword kinds
  typedef enum logic [2:0] {
    UW_NONE   = 3'h0,
    UW_SETRST = 3'h1,
    UW_BRANCH = 3'h2,
    UW_RETURN = 3'h3,
    UW_EXTRD  = 3'h4,
    UW_EXTWR  = 3'h5,
    UW_LSOP   = 3'h6
  } lszd_uword_type;

  // external facility selectors used by this block
  typedef enum logic [2:0] {
    FAC_NONE  = 3'h0,
    FAC_DIAG  = 3'h1,
    FAC_MASK  = 3'h2,
    FAC_MODE  = 3'h3,
    FAC_STAT  = 3'h4,
    FAC_TIMER = 3'h5,
    FAC_BRCND = 3'h6
  } lszd_fac_type;

  localparam logic [3:0] DISP_SEL_TIMER = 4'hA;

  // bit numbering helper: bit n counted from the left of a byte
  function automatic int lbit(input int n);
    return 7 - n;
  endfunction

endpackage

/* File: hdl/lszd_store.sv */
// Purpose: local storage array, 128 bytes addressed by zone and field
// Assumes: single write port, registered read ports
// Notes:   shared upper locations are folded by the caller

`timescale 1ns/100ps

module lszd_store #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          sys_clk,
  input  wire logic [AW-1:0] rdAddrA,
  input  wire logic [AW-1:0] rdAddrB,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  output      logic [DW-1:0] rdDataA,
  output      logic [DW-1:0] rdDataB
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdDataA <= mem[rdAddrA];
    rdDataB <= mem[rdAddrB];
  end

endmodule // lszd_store

/* File: hdl/lszd_zone_decode.sv */
// Purpose: local storage zone decode, diagnostic, mask, mode and status regs
// Assumes: sequencer presents one microword per sys_clk cycle
// Notes:   bit 0 of any byte is its leftmost (most significant) bit
//
// Functional notes
// - location chosen from 4-bit operand field plus zone from mode bits 5-7
// - zone from mode register normally, from mask register during traps
// - zone 0 cpu, 1 disk, 4 backups, 5 comm channel, 6 card unit
// - zones 4 to 7, decodes 1000-1111 share one set of locations
// - disk zone upper decodes hold count, data addr, flags, command, next addr
// - cpu zone 1000/1001 instruction counter, 1111 counter top byte
// - cpu zone decode 1010 is zero at start of each fetch sequence
// - cpu zone 1100 condition code, 1101 program mask and state bits
// - comm zone lower decodes hold line control word address, pointer, bytes
// - card zone lower decodes hold buffer addrs, trap counts, indicators
// - diagnostic reg loaded by set/reset only; bit 7 on branch sets latch
// - mask bits 0-9 by set/reset; other accesses and display bits 0-7
// - mode display: mode decode bits 2-4, effective zone bits 5-7
// - status reg set/reset by set/reset word, used as branch conditions
// - status display bits 0-6 direct, bit 7 branch line; latch in BA bit 0
// - set/reset-only facilities ignore ordinary external reads and writes
// - timer count readable in cpu mode, displayed at selector A in cpu mode only

`timescale 1ns/100ps

module lszd_zone_decode #(
  parameter int FW = 4,
  parameter int ZW = 3
) (
  input  wire logic                      sys_clk,
  input  wire logic                      nrst,
  // microword
  input  wire lszd_pkg::lszd_uword_type  uwKind,
  input  wire logic [FW-1:0]             source_operand_field,
  input  wire logic [FW-1:0]             dest_operand_field,
  input  wire lszd_pkg::lszd_fac_type    facSel,
  input  wire logic [7:0]                srSetBits,
  input  wire logic [7:0]                srResetBits,
  input  wire logic [1:0]                srMaskHiSet,
  input  wire logic [1:0]                srMaskHiReset,
  input  wire logic                      trapActive,
  input  wire logic                      fetchStart,
  input  wire logic                      cpuMode,
  input  wire logic                      s7BranchLine,
  input  wire logic [7:0]                timer_count_facility,
  // local storage write
  input  wire logic                      lsWrEn,
  input  wire logic [7:0]                lsWrData,
  input  wire logic [3:0]                dispSelD,
  // outputs
  output      logic [ZW+FW-1:0]          lsAddrSrc,
  output      logic [ZW+FW-1:0]          lsAddrDst,
  output      logic [ZW-1:0]             zoneEff,
  output      logic [7:0]                lsRdSrc,
  output      logic [7:0]                lsRdDst,
  output      logic [7:0]                extRdData,
  output      logic                      extRdValid,
  output      logic [7:0]                dispData,
  output      logic                      diagBranchLatch,
  output      logic [7:0]                statusBranchCond,
  output      logic [7:0]                branchCondFac,
  output      logic [7:0]                modeDisplay,
  output      logic [7:0]                statusDisplay,
  output      logic [9:0]                microprogram_mask_reg,
  output      logic [7:0]                diagnostic_reg,
  output      logic [7:0]                modeReg
);

  // =========================================================================
  // registers
  logic [7:0] modeQ;
  logic [7:0] modeD;
  logic [9:0] maskQ;
  logic [9:0] maskD;
  logic [7:0] diagQ;
  logic [7:0] diagD;
  logic [7:0] statQ;
  logic [7:0] statD;
  logic       diagBrQ;
  logic       diagBrD;
  logic       clrPendQ;
  logic       clrPendD;
  logic [7:0] extRdQ;
  logic [7:0] extRdD;
  logic       extVldQ;
  logic       extVldD;
  logic [7:0] dispQ;
  logic [7:0] dispD;

  // =========================================================================
  // microword kind decode
  wire isSetRst = (uwKind == lszd_pkg::UW_SETRST);
  wire isBranch = (uwKind == lszd_pkg::UW_BRANCH);
  wire isReturn = (uwKind == lszd_pkg::UW_RETURN);
  wire isExtRd  = (uwKind == lszd_pkg::UW_EXTRD);
  wire isExtWr  = (uwKind == lszd_pkg::UW_EXTWR);

  // set/reset update of one byte; set wins over reset
  function automatic logic [7:0] srByte(input logic [7:0] cur,
                                        input logic [7:0] setB,
                                        input logic [7:0] rstB);
    return (cur & ~rstB) | setB;
  endfunction

  // byte bit n (counted from the left) of a value
  function automatic logic lb(input logic [7:0] v, input int n);
    return v[7-n];
  endfunction

  // =========================================================================
  // zone selection
  wire [ZW-1:0] modeZone = modeQ[ZW-1:0];
  wire [ZW-1:0] maskZone = maskQ[ZW-1:0];
  assign zoneEff = trapActive ? maskZone : modeZone;

  // shared upper half of zones 4-7 folds onto zone 4
  function automatic logic [ZW+FW-1:0] lsAddr(input logic [ZW-1:0] z,
                                               input logic [FW-1:0] f);
    logic [ZW-1:0] zf;
    zf = z;
    if (z[ZW-1] && f[FW-1]) begin
      zf = lszd_pkg::ZONE_BACKUP;
    end
    return {zf, f};
  endfunction

  assign lsAddrSrc = lsAddr(zoneEff, source_operand_field);
  assign lsAddrDst = lsAddr(zoneEff, dest_operand_field);

  // =========================================================================
  // local storage: zones 0/1/4/5/6 hold the area bytes by address
  // cpu counters, cc, psw bits disk words
  // line control word and card unit words live at zone:field
  wire [ZW+FW-1:0] workZeroAddr = {lszd_pkg::ZONE_CPU, lszd_pkg::FLD_WORK_ZERO};
  // repeated clear yields to a fresh write so back-to-back words are kept
  wire             wrZero       = fetchStart | (clrPendQ & ~lsWrEn);
  wire             memWrEn      = lsWrEn | wrZero;
  wire [ZW+FW-1:0] memWrAddr    = wrZero ? workZeroAddr : lsAddrDst;
  wire [7:0]       memWrData    = wrZero ? 8'h00 : lsWrData;

  lszd_store #(
    .AW (ZW+FW),
    .DW (8)
  ) uStore (
    .sys_clk (sys_clk),
    .rdAddrA (lsAddrSrc),
    .rdAddrB (lsAddrDst),
    .wrEn    (memWrEn),
    .wrAddr  (memWrAddr),
    .wrData  (memWrData),
    .rdDataA (lsRdSrc),
    .rdDataB (lsRdDst)
  );

  // an ordinary write to cpu zone 1010 colliding with the fetch clear is retried as a clear
  assign clrPendD = fetchStart & lsWrEn & (lsAddrDst == workZeroAddr);

  // =========================================================================
  // register updates
  wire srMode = isSetRst & (facSel == lszd_pkg::FAC_MODE);
  wire srMask = isSetRst & (facSel == lszd_pkg::FAC_MASK);
  wire srDiag = isSetRst & (facSel == lszd_pkg::FAC_DIAG);
  wire srStat = isSetRst & (facSel == lszd_pkg::FAC_STAT);
  wire wrMask = isExtWr & (facSel == lszd_pkg::FAC_MASK);

  assign modeD = srMode ? srByte(modeQ, srSetBits, srResetBits) : modeQ;
  assign diagD = srDiag ? srByte(diagQ, srSetBits, srResetBits) : diagQ;
  assign statD = srStat ? srByte(statQ, srSetBits, srResetBits) : statQ;

  // mask: wide set/reset reaches bits 0-9; ordinary write only bits 0-7
  wire [9:0] maskSr = {(maskQ[9:8] & ~srMaskHiReset) | srMaskHiSet,
                       srByte(maskQ[7:0], srSetBits, srResetBits)};
  assign maskD = srMask ? maskSr :
                 wrMask ? {maskQ[9:8], lsWrData} : maskQ;

  // branch or return with diagnostic bit 7 on sets the latch
  wire diagArm = (isBranch | isReturn) & lb(diagQ, lszd_pkg::DIAG_BR_BIT);
  assign diagBrD = diagArm | diagBrQ;

  // =========================================================================
  // ordinary external reads; set/reset-only facilities answer nothing
  logic [7:0] extSel;
  logic       extOk;
  always_comb begin
    extSel = 8'h00;
    extOk  = 1'b0;
    case (facSel)
      lszd_pkg::FAC_MASK: begin
        extSel = maskQ[7:0];
        extOk  = 1'b1;
      end
      lszd_pkg::FAC_TIMER: begin
        extSel = timer_count_facility;
        extOk  = cpuMode;
      end
      lszd_pkg::FAC_BRCND: begin
        extSel = branchCondFac;
        extOk  = 1'b1;
      end
      default: begin
        extSel = 8'h00;
        extOk  = 1'b0;
      end
    endcase
  end

  assign extVldD = isExtRd & extOk;
  assign extRdD  = (isExtRd & extOk) ? extSel : 8'h00;

  // =========================================================================
  // displays
  wire [2:0] modeDec = modeQ[5:3];
  assign modeDisplay = {2'b00, modeDec, zoneEff};
  // bit 7 (leftmost index 7 = lsb) shows the branch line, not the latch
  assign statusDisplay = {statQ[7:1], s7BranchLine};
  assign branchCondFac = {statQ[0], 7'h00};
  assign statusBranchCond = statQ;

  // display selector: D value A picks the timer in cpu mode, otherwise facSel picks the facility shown
  wire dispTimer = cpuMode & (dispSelD == lszd_pkg::DISP_SEL_TIMER);
  logic [7:0] dispSel;
  always_comb begin
    dispSel = 8'h00;
    case (facSel)
      lszd_pkg::FAC_MODE:  dispSel = modeDisplay;
      lszd_pkg::FAC_STAT:  dispSel = statusDisplay;
      lszd_pkg::FAC_MASK:  dispSel = maskQ[7:0];
      lszd_pkg::FAC_DIAG:  dispSel = diagQ;
      lszd_pkg::FAC_BRCND: dispSel = branchCondFac;
      default:             dispSel = 8'h00;
    endcase
  end
  assign dispD = dispTimer ? timer_count_facility : dispSel;

  // =========================================================================
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      modeQ    <= lszd_pkg::MODE_RST;
      maskQ    <= lszd_pkg::MASK_RST;
      diagQ    <= lszd_pkg::DIAG_RST;
      statQ    <= lszd_pkg::STAT_RST;
      diagBrQ  <= 1'b0;
      clrPendQ <= 1'b0;
    end else begin
      modeQ    <= modeD;
      maskQ    <= maskD;
      diagQ    <= diagD;
      statQ    <= statD;
      diagBrQ  <= diagBrD;
      clrPendQ <= clrPendD;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      extRdQ  <= 8'h00;
      extVldQ <= 1'b0;
      dispQ   <= 8'h00;
    end else begin
      extRdQ  <= extRdD;
      extVldQ <= extVldD;
      dispQ   <= dispD;
    end
  end

  assign extRdData             = extRdQ;
  assign extRdValid            = extVldQ;
  assign dispData              = dispQ;
  assign diagBranchLatch       = diagBrQ;
  assign microprogram_mask_reg = maskQ;
  assign diagnostic_reg        = diagQ;
  assign modeReg               = modeQ;

endmodule // lszd_zone_decode

/* File: tb/lszd_zone_chk.sv */
// Purpose: concurrent checks on the zone decode ports
// Assumes: one clock domain, async active-low reset
// Notes:   bit 0 of a byte is the vector msb
`timescale 1ns/100ps
module lszd_zone_chk #(
  parameter int FW = 4,
  parameter int ZW = 3
) (
  input wire logic                     sys_clk,
  input wire logic                     nrst,
  input wire lszd_pkg::lszd_uword_type uwKind,
  input wire logic [FW-1:0]            source_operand_field,
  input wire logic [FW-1:0]            dest_operand_field,
  input wire lszd_pkg::lszd_fac_type   facSel,
  input wire logic [7:0]               srSetBits,
  input wire logic [7:0]               srResetBits,
  input wire logic                     trapActive,
  input wire logic                     cpuMode,
  input wire logic                     s7BranchLine,
  input wire logic [7:0]               timer_count_facility,
  input wire logic [ZW+FW-1:0]         lsAddrSrc,
  input wire logic [ZW+FW-1:0]         lsAddrDst,
  input wire logic [ZW-1:0]            zoneEff,
  input wire logic [7:0]               extRdData,
  input wire logic                     extRdValid,
  input wire logic                     diagBranchLatch,
  input wire logic [7:0]               statusBranchCond,
  input wire logic [7:0]               branchCondFac,
  input wire logic [7:0]               modeDisplay,
  input wire logic [7:0]               statusDisplay,
  input wire logic [9:0]               microprogram_mask_reg,
  input wire logic [7:0]               diagnostic_reg,
  input wire logic [7:0]               modeReg
);
  // ==========================================================================
  // expected addresses, shared upper half of zones 4-7 folds to zone 4
  wire logic [ZW+FW-1:0] expSrc;
  wire logic [ZW+FW-1:0] expDst;
  assign expSrc = (zoneEff[2] && source_operand_field[3]) ? {3'h4, source_operand_field}
                                                          : {zoneEff, source_operand_field};
  assign expDst = (zoneEff[2] && dest_operand_field[3]) ? {3'h4, dest_operand_field}
                                                        : {zoneEff, dest_operand_field};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // assertions
  chk_addr_src: assert property (lsAddrSrc == expSrc)
    else $error("source address not zone above field");
  chk_addr_dst: assert property (lsAddrDst == expDst)
    else $error("destination address not zone above field");
  chk_zone_sel: assert property (zoneEff == (trapActive ? microprogram_mask_reg[2:0]
    : modeReg[2:0])) else $error("effective zone from wrong register");
  chk_diag_latch: assert property ((uwKind inside {lszd_pkg::UW_BRANCH,
    lszd_pkg::UW_RETURN} && diagnostic_reg[0]) |=> diagBranchLatch)
    else $error("branch latch not set");
  chk_diag_only: assert property (uwKind != lszd_pkg::UW_SETRST
    |=> $stable(diagnostic_reg)) else $error("diagnostic reg changed without set/reset word");
  chk_mask_narrow: assert property ((uwKind == lszd_pkg::UW_EXTWR && facSel ==
    lszd_pkg::FAC_MASK) |=> $stable(microprogram_mask_reg[9:8])) else $error("mask high bits hit");
  chk_ext_refuse: assert property ((uwKind == lszd_pkg::UW_EXTRD && facSel inside
    {lszd_pkg::FAC_DIAG, lszd_pkg::FAC_MODE, lszd_pkg::FAC_STAT}) |=> (!extRdValid
    && extRdData == 8'h00)) else $error("set/reset facility readable");
  chk_ext_mask: assert property ((uwKind == lszd_pkg::UW_EXTRD
    && facSel == lszd_pkg::FAC_MASK)
    |=> (extRdValid && extRdData == $past(microprogram_mask_reg[7:0])))
    else $error("mask read wrong");
  chk_timer_rd: assert property ((uwKind == lszd_pkg::UW_EXTRD && facSel ==
    lszd_pkg::FAC_TIMER && cpuMode) |=> (extRdValid && extRdData == $past(timer_count_facility)))
    else $error("timer read wrong");
  chk_stat_sr: assert property ((uwKind == lszd_pkg::UW_SETRST
    && facSel == lszd_pkg::FAC_STAT)
    |=> statusBranchCond == (($past(statusBranchCond) & ~$past(srResetBits)) | $past(srSetBits)))
    else $error("status set/reset wrong");
  chk_mode_disp: assert property (modeDisplay == {2'b00, modeReg[5:3], zoneEff})
    else $error("mode display wrong");
  chk_stat_disp: assert property (statusDisplay == {statusBranchCond[7:1], s7BranchLine}
    && branchCondFac[7] == statusBranchCond[0]) else $error("status display wrong");
endmodule // lszd_zone_chk

bind lszd_zone_decode lszd_zone_chk #(.FW(FW), .ZW(ZW)) u_lszd_zone_chk (
  .sys_clk, .nrst, .uwKind, .source_operand_field, .dest_operand_field, .facSel, .srSetBits,
  .srResetBits, .trapActive, .cpuMode, .s7BranchLine, .timer_count_facility, .lsAddrSrc,
  .lsAddrDst, .zoneEff, .extRdData, .extRdValid, .diagBranchLatch, .statusBranchCond,
  .branchCondFac, .modeDisplay, .statusDisplay, .microprogram_mask_reg, .diagnostic_reg, .modeReg
);

/* File: tb/lszd_seq_model.sv */
// Purpose: microprogram sequencer model, one microword per cycle
// Assumes: design takes every field on the rising edge
// Notes:   fields change on the falling edge only
`timescale 1ns/100ps
module lszd_seq_model (
  input  wire logic                   sys_clk,
  output lszd_pkg::lszd_uword_type    uwKind,
  output lszd_pkg::lszd_fac_type      facSel,
  output logic [7:0]                  srSetBits,
  output logic [7:0]                  srResetBits,
  output logic [1:0]                  srMaskHiSet,
  output logic [1:0]                  srMaskHiReset,
  output logic [3:0]                  source_operand_field,
  output logic [3:0]                  dest_operand_field,
  output logic                        lsWrEn,
  output logic [7:0]                  lsWrData,
  output logic                        fetchStart
);
  initial begin
    uwKind = lszd_pkg::UW_NONE;
    facSel = lszd_pkg::FAC_NONE;
    {srSetBits, srResetBits, srMaskHiSet, srMaskHiReset} = 20'h00000;
    {source_operand_field, dest_operand_field, lsWrEn, lsWrData, fetchStart} = 18'h00000;
  end
  // ==========================================================================
  // facility microword
  task automatic uw(input lszd_pkg::lszd_uword_type k, input lszd_pkg::lszd_fac_type f,
                    input logic [7:0] s, input logic [7:0] r, input logic [3:0] hi);
    @(negedge sys_clk);
    uwKind = k;
    facSel = f;
    {srSetBits, srResetBits, srMaskHiSet, srMaskHiReset} = {s, r, hi};
    lsWrEn = 1'b0;
    fetchStart = 1'b0;
  endtask
  // ==========================================================================
  // local storage microword
  task automatic ls(input logic [3:0] src, input logic [3:0] dst, input logic we,
                    input logic [7:0] d, input logic fs);
    @(negedge sys_clk);
    uwKind = lszd_pkg::UW_NONE;
    facSel = lszd_pkg::FAC_NONE;
    {source_operand_field, dest_operand_field, lsWrEn, lsWrData, fetchStart} = {src, dst, we, d, fs};
  endtask
endmodule // lszd_seq_model

/* File: tb/tb.sv */
// Purpose: self-checking bench for the zone decode block
// Assumes: inputs change on the falling edge
// Notes:   registered outputs are looked at one cycle after the word
`timescale 1ns/100ps
module tb;
  logic sys_clk, nrst, trapActive, cpuMode, s7BranchLine;
  logic [7:0] timer_count_facility, srSetBits, srResetBits, lsWrData;
  logic [3:0] dispSelD, source_operand_field, dest_operand_field;
  logic [1:0] srMaskHiSet, srMaskHiReset;
  logic lsWrEn, fetchStart, extRdValid, diagBranchLatch;
  lszd_pkg::lszd_uword_type uwKind;
  lszd_pkg::lszd_fac_type   facSel;
  logic [6:0] lsAddrSrc, lsAddrDst;
  logic [2:0] zoneEff;
  logic [7:0] lsRdSrc, lsRdDst, extRdData, dispData, statusBranchCond, branchCondFac;
  logic [7:0] modeDisplay, statusDisplay, diagnostic_reg, modeReg;
  logic [9:0] microprogram_mask_reg;
  int fail_count = 0;
  int comparisons = 0;
  lszd_seq_model u_lszd_seq_model (.sys_clk, .uwKind, .facSel, .srSetBits, .srResetBits,
    .srMaskHiSet, .srMaskHiReset, .source_operand_field, .dest_operand_field, .lsWrEn,
    .lsWrData, .fetchStart);
  lszd_zone_decode u_lszd_zone_decode (.sys_clk, .nrst, .uwKind, .source_operand_field,
    .dest_operand_field, .facSel, .srSetBits, .srResetBits, .srMaskHiSet, .srMaskHiReset,
    .trapActive, .fetchStart, .cpuMode, .s7BranchLine, .timer_count_facility, .lsWrEn,
    .lsWrData, .dispSelD, .lsAddrSrc, .lsAddrDst, .zoneEff, .lsRdSrc, .lsRdDst, .extRdData,
    .extRdValid, .dispData, .diagBranchLatch, .statusBranchCond, .branchCondFac, .modeDisplay,
    .statusDisplay, .microprogram_mask_reg, .diagnostic_reg, .modeReg);
  // ==========================================================================
  // helpers
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic idle();
    u_lszd_seq_model.ls(4'h0, 4'h0, 1'b0, 8'h00, 1'b0);
  endtask
  task automatic setmode(input logic [7:0] v);
    u_lszd_seq_model.uw(lszd_pkg::UW_SETRST, lszd_pkg::FAC_MODE, v, 8'hFF, 4'h0);
  endtask
  task automatic wr(input logic [7:0] v, input logic [3:0] f, input logic [7:0] d);
    setmode(v);
    u_lszd_seq_model.ls(4'h0, f, 1'b1, d, 1'b0);
  endtask
  task automatic rd(input logic [7:0] v, input logic [3:0] f, input logic [7:0] e);
    setmode(v);
    u_lszd_seq_model.ls(f, f, 1'b0, 8'h00, 1'b0);
    idle();
    chk(lsRdSrc, e, "storage read");
    chk(lsRdDst, e, "storage read dst");
  endtask
  task automatic ext(input lszd_pkg::lszd_fac_type f, input logic v, input logic [7:0] e);
    u_lszd_seq_model.uw(lszd_pkg::UW_EXTRD, f, 8'h00, 8'h00, 4'h0);
    idle();
    chk({extRdValid, extRdData}, {v, e}, "external read");
  endtask
  // ==========================================================================
  // clock, reset, watchdog
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #(50 * 2000);
    fail_count++;
    stop_test();
  end
  // ==========================================================================
  // scenarios
  initial begin
    logic [2:0] zl [5];
    zl = '{lszd_pkg::ZONE_CPU, lszd_pkg::ZONE_DISK, lszd_pkg::ZONE_BACKUP,
           lszd_pkg::ZONE_COMM, lszd_pkg::ZONE_CARD};
    {nrst, trapActive, cpuMode, s7BranchLine} = 4'h0;
    timer_count_facility = 8'hA5;
    dispSelD = lszd_pkg::DISP_SEL_TIMER;
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
    chk({modeReg, diagnostic_reg, statusBranchCond}, 24'h0, "reset regs");
    chk(microprogram_mask_reg, lszd_pkg::MASK_RST, "mask reset");
    foreach (zl[i]) begin
      setmode({5'h00, zl[i]});
      u_lszd_seq_model.ls(4'h3, 4'hB, 1'b0, 8'h00, 1'b0);
      #1;
      chk(zoneEff, zl[i], "zone");
      chk(lsAddrSrc, {zl[i], 4'h3}, "address");
      chk(lsAddrDst, {zl[i][2] ? lszd_pkg::ZONE_BACKUP : zl[i], 4'hB}, "fold");
    end
    wr(8'h05, 4'h8, 8'h3C);
    wr(8'h05, 4'h0, 8'h22);
    wr(8'h06, 4'h0, 8'h11);
    rd(8'h06, 4'h8, 8'h3C);
    rd(8'h07, 4'h8, 8'h3C);
    rd(8'h05, 4'h0, 8'h22);
    rd(8'h06, 4'h0, 8'h11);
    wr(8'h00, lszd_pkg::FLD_WORK_ZERO, 8'h5A);
    rd(8'h00, lszd_pkg::FLD_WORK_ZERO, 8'h5A);
    u_lszd_seq_model.ls(4'h0, 4'h0, 1'b0, 8'h00, 1'b1);
    rd(8'h00, lszd_pkg::FLD_WORK_ZERO, 8'h00);
    u_lszd_seq_model.uw(lszd_pkg::UW_SETRST, lszd_pkg::FAC_MASK, 8'h06, 8'h00, 4'hC);
    trapActive = 1'b1;
    idle();
    chk(microprogram_mask_reg, 10'h306, "mask set/reset");
    chk(zoneEff, 3'h6, "trap zone");
    ext(lszd_pkg::FAC_MASK, 1'b1, 8'h06);
    trapActive = 1'b0;
    u_lszd_seq_model.ls(4'h0, 4'h0, 1'b0, 8'h9C, 1'b0);
    u_lszd_seq_model.uw(lszd_pkg::UW_EXTWR, lszd_pkg::FAC_MASK, 8'h00, 8'h00, 4'h0);
    idle();
    chk(microprogram_mask_reg, 10'h39C, "mask ext write");
    setmode(8'h2D);
    idle();
    chk(modeDisplay, 8'h2D, "mode display");
    u_lszd_seq_model.uw(lszd_pkg::UW_BRANCH, lszd_pkg::FAC_NONE, 8'h00, 8'h00, 4'h0);
    idle();
    chk(diagBranchLatch, 1'b0, "latch idle");
    u_lszd_seq_model.uw(lszd_pkg::UW_SETRST, lszd_pkg::FAC_DIAG, 8'h01, 8'h00, 4'h0);
    u_lszd_seq_model.uw(lszd_pkg::UW_EXTWR, lszd_pkg::FAC_DIAG, 8'h00, 8'h00, 4'h0);
    u_lszd_seq_model.uw(lszd_pkg::UW_RETURN, lszd_pkg::FAC_NONE, 8'h00, 8'h00, 4'h0);
    idle();
    chk({diagnostic_reg, diagBranchLatch}, 9'h003, "diag latch");
    ext(lszd_pkg::FAC_DIAG, 1'b0, 8'h00);
    u_lszd_seq_model.uw(lszd_pkg::UW_SETRST, lszd_pkg::FAC_STAT, 8'h81, 8'h00, 4'h0);
    idle();
    chk({statusDisplay, branchCondFac[7]}, 9'h101, "status display");
    ext(lszd_pkg::FAC_BRCND, 1'b1, 8'h80);
    u_lszd_seq_model.uw(lszd_pkg::UW_SETRST, lszd_pkg::FAC_STAT, 8'h00, 8'h01, 4'h0);
    s7BranchLine = 1'b1;
    idle();
    chk({statusBranchCond, statusDisplay[0]}, 9'h101, "status reset");
    ext(lszd_pkg::FAC_STAT, 1'b0, 8'h00);
    chk(dispData, 8'h81, "status shown");
    cpuMode = 1'b1;
    ext(lszd_pkg::FAC_TIMER, 1'b1, 8'hA5);
    chk(dispData, 8'hA5, "timer display");
    cpuMode = 1'b0;
    ext(lszd_pkg::FAC_TIMER, 1'b0, 8'h00);
    stop_test();
  end
endmodule // tb
